//--- dpe_cfg.svh
// Offsets, field positions and reset values of the data-path enable block
`ifndef DPE_CFG_SVH
`define DPE_CFG_SVH

// Register byte offsets, one aligned word each
`define DPE_CTRL_OFS      4'h0
`define DPE_TIMING_OFS    4'h4
`define DPE_STATUS_OFS    4'h8

// Control field positions
`define DPE_CTRL_TYPE_LSB  0
`define DPE_CTRL_TYPE_MSB  1
`define DPE_CTRL_SPLIT_BIT 2
`define DPE_CTRL_MASK_LSB  4
`define DPE_CTRL_MASK_MSB  7

// Timing field positions
`define DPE_TIM_TURN_LSB   0
`define DPE_TIM_TURN_MSB   3
`define DPE_TIM_MARG_LSB   4
`define DPE_TIM_MARG_MSB   7

// Status field positions
`define DPE_STAT_BUSY_BIT  0
`define DPE_STAT_ERR_BIT   1
`define DPE_STAT_ST_LSB    4
`define DPE_STAT_ST_MSB    8
`define DPE_STAT_CNT_LSB   16
`define DPE_STAT_CNT_MSB   31

// Reset values
`define DPE_CTRL_RST       8'hf4
`define DPE_TIMING_RST     8'h00
`define DPE_COUNT_RST      16'h0000

`endif

//--- dpe_pkg.sv
// Types shared by the data-path enable block
package dpe_pkg;

	// Kind of external data-path buffer
	typedef enum logic [1:0] {
		DPE_PLAIN   = 2'h0,
		DPE_LATCHED = 2'h1,
		DPE_REGD    = 2'h2
	} dpe_path_t;

	// Access sequencer states
	typedef enum logic [4:0] {
		DPE_ST_IDLE = 5'h01,
		DPE_ST_ROW  = 5'h02,
		DPE_ST_COL  = 5'h04,
		DPE_ST_TAIL = 5'h08,
		DPE_ST_TURN = 5'h10
	} dpe_state_t;

endpackage : dpe_pkg

//--- dpe_if.sv
// Phase and enable signals between sequencer and enable decoder
`timescale 1ns/10ps
interface dpe_if;
	import dpe_pkg::*;
	dpe_path_t path_type;
	logic      rd_phase;
	logic      wr_phase;
	logic      odd_path;
	logic      even_rd;
	logic      odd_rd;
	logic      even_wr;
	logic      odd_wr;

	modport ctl (output path_type, output rd_phase, output wr_phase, output odd_path,
		input even_rd, input odd_rd, input even_wr, input odd_wr);
	modport dec (input path_type, input rd_phase, input wr_phase, input odd_path,
		output even_rd, output odd_rd, output even_wr, output odd_wr);
endinterface : dpe_if

//--- dpe_decode.sv
// Enable decoder: maps access phase and buffer kind onto the four path enables
`timescale 1ns/10ps
module dpe_decode
	import dpe_pkg::*;
(
	dpe_if.dec bus
);

	// Active-high enables; the sequencer registers and inverts them
	always_comb begin
		bus.even_rd = 1'b0;
		bus.odd_rd  = 1'b0;
		bus.even_wr = 1'b0;
		bus.odd_wr  = 1'b0;
		case (bus.path_type)
			DPE_LATCHED: begin
				bus.even_rd = bus.rd_phase;                  // R4
				bus.odd_rd  = bus.rd_phase & bus.odd_path;   // R5
				bus.even_wr = bus.wr_phase & ~bus.odd_path;  // R6
				bus.odd_wr  = bus.wr_phase & bus.odd_path;   // R6
			end
			DPE_REGD: begin
				bus.even_rd = bus.rd_phase & ~bus.odd_path;  // R8
				bus.odd_rd  = bus.rd_phase & bus.odd_path;   // R8
				bus.even_wr = bus.wr_phase & ~bus.odd_path;  // R8
				bus.odd_wr  = bus.wr_phase & bus.odd_path;   // R8
			end
			default: begin
				// Read enable is the buffer's output enable for both directions
				bus.even_rd = (bus.rd_phase | bus.wr_phase) & ~bus.odd_path; // R1
				bus.odd_rd  = (bus.rd_phase | bus.wr_phase) & bus.odd_path;  // R1
				// Write enables serve as direction control
				bus.even_wr = bus.wr_phase & ~bus.odd_path;
				bus.odd_wr  = bus.wr_phase & bus.odd_path;
			end
		endcase
	end

endmodule : dpe_decode

//--- dpe_top.sv
// DRAM data-path enable sequencer with Avalon-MM configuration registers
//
// Overview of operation
// R1: Plain transceiver: read enable is buffer output enable on reads and writes.
// R2: Plain transceiver: no address pipelining on burst reads, no read latch.
// R3: Board derives plain transceiver direction from system read or write strobe.
// R4: Latched mux: even read enable is common read path enable for all reads.
// R5: Latched mux: odd read enable latches odd data and selects the mux path.
// R6: Latched mux: odd and even write enables drive the write path enables.
// R7: Latched types pipeline burst reads, finishing one clock before plain type.
// R8: Registered transceiver: read and write enables map to matching path enables.
// R9: One to four banks; strobes 0,2 even path, strobes 1,3 odd path.
// R10: Interleave even and odd banks only with separate even and odd buffers.
// R11: Banks must ignore column strobe arriving without their row strobe.
// R12: Single shared buffer set: no interleave, read enables OR'ed externally.
// R13: Direct attach: turnaround setting keeps reads clear of following writes.
// R14: Heavy address loading: software adds timing margin or board buffers.
// R15: Unused data path keeps its read and write enables deasserted.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "dpe_cfg.svh"
module dpe_top
	import dpe_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        acc_valid,
	input  wire logic        acc_write,
	input  wire logic [1:0]  acc_bank,
	input  wire logic [2:0]  acc_beats,
	input  wire logic        acc_interleave,
	output logic             acc_ready,
	output logic             acc_beat,
	output logic             acc_done,
	output logic             acc_error,
	output logic      [3:0]  row_strobe_n,
	output logic             col_strobe_n,
	output logic             even_read_path_enable_n,
	output logic             odd_read_path_enable_n,
	output logic             even_write_path_enable_n,
	output logic             odd_write_path_enable_n
);

	// One-hot row strobe mask of a bank, used for both banks of a pair
	function automatic logic [3:0] bank_mask(input logic [1:0] bank);
		bank_mask = 4'h1 << bank;
	endfunction : bank_mask

	// Buffer kind from the control field; the spare code falls back to plain
	function automatic dpe_path_t path_of(input logic [1:0] code);
		case (code)
			2'h1:    path_of = DPE_LATCHED;
			2'h2:    path_of = DPE_REGD;
			default: path_of = DPE_PLAIN;
		endcase
	endfunction : path_of

	// Configuration and status storage
	logic [7:0]       ctrl_r;
	logic [7:0]       timing_r;
	logic             err_r;
	logic [CNT_W-1:0] count_r;
	logic [31:0]      readdata_r;
	logic             waitreq_r;

	// Sequencer storage
	dpe_state_t state_r;
	logic [3:0] cnt_r;
	logic [2:0] beats_left_r;
	logic       cur_odd_r;
	logic       lat_write_r;
	logic       lat_il_r;
	logic       lat_burst_r;
	logic [3:0] rows_r;
	logic       ready_r;
	logic       beat_r;
	logic       done_r;
	logic       err_pulse_r;

	// Registered pin images
	logic [3:0] row_n_r;
	logic       col_n_r;
	logic       erd_n_r;
	logic       ord_n_r;
	logic       ewr_n_r;
	logic       owr_n_r;

	// Decoded configuration
	dpe_path_t  ptype;
	logic       split_paths;
	logic [3:0] present;
	logic [3:0] turn_cycles;
	logic [3:0] margin;
	logic       bus_take;
	logic       bus_wr_now;
	logic       start;
	logic       bank_absent;
	logic       last_beat;
	logic       beat_now;
	logic       err_set;
	logic       err_clr;
	logic       il_ok;

	dpe_if dif ();

	assign ptype       = path_of(ctrl_r[`DPE_CTRL_TYPE_MSB:`DPE_CTRL_TYPE_LSB]);
	assign split_paths = ctrl_r[`DPE_CTRL_SPLIT_BIT];
	assign present     = ctrl_r[`DPE_CTRL_MASK_MSB:`DPE_CTRL_MASK_LSB];
	assign turn_cycles = timing_r[`DPE_TIM_TURN_MSB:`DPE_TIM_TURN_LSB];
	assign margin      = timing_r[`DPE_TIM_MARG_MSB:`DPE_TIM_MARG_LSB];

	// Bus handshake: request seen while waitrequest high, taken while it is low
	assign bus_take   = (avs_read | avs_write) & waitreq_r;
	assign bus_wr_now = avs_write & ~waitreq_r;

	// Access start and its qualifiers
	assign start       = acc_valid & ready_r;
	assign bank_absent = ~present[acc_bank];                   // R9
	// Pair interleave only with separate buffer sets and both banks fitted
	assign il_ok       = acc_interleave & split_paths & present[acc_bank ^ 2'h1]; // R10
	assign beat_now    = (state_r == DPE_ST_COL) && (cnt_r == 4'h0);
	assign last_beat   = beat_now && (beats_left_r == 3'h1);

	// Sticky error: set on an access to a missing bank, write one to clear
	assign err_set = start & bank_absent;
	assign err_clr = bus_wr_now && (avs_address == `DPE_STATUS_OFS) && avs_byteenable[0]
		&& avs_writedata[`DPE_STAT_ERR_BIT];

	// Phase information toward the enable decoder
	assign dif.path_type = ptype;
	assign dif.rd_phase  = ((state_r == DPE_ST_COL) || (state_r == DPE_ST_TAIL)) && !lat_write_r;
	assign dif.wr_phase  = ((state_r == DPE_ST_COL) || (state_r == DPE_ST_TAIL)) && lat_write_r;
	assign dif.odd_path  = cur_odd_r;                          // R9

	dpe_decode u_dec (
		.bus (dif.dec)
	);

	// Avalon waitrequest: low for exactly one cycle per request
	always_ff @(posedge clk) begin
		if (srst) begin
			waitreq_r <= 1'b1;
		end else if (bus_take) begin
			waitreq_r <= 1'b0;
		end else begin
			waitreq_r <= 1'b1;
		end
	end

	// Read data captured when the request is first seen, held through the answer
	always_ff @(posedge clk) begin
		if (srst) begin
			readdata_r <= 32'h0000_0000;
		end else if (bus_take && avs_read) begin
			case (avs_address)
				`DPE_CTRL_OFS:   readdata_r <= {24'h00_0000, ctrl_r};
				`DPE_TIMING_OFS: readdata_r <= {24'h00_0000, timing_r};
				`DPE_STATUS_OFS: begin
					readdata_r <= 32'h0000_0000;
					readdata_r[`DPE_STAT_BUSY_BIT] <= (state_r != DPE_ST_IDLE);
					readdata_r[`DPE_STAT_ERR_BIT] <= err_r;
					readdata_r[`DPE_STAT_ST_MSB:`DPE_STAT_ST_LSB] <= state_r;
					readdata_r[`DPE_STAT_CNT_MSB:`DPE_STAT_CNT_LSB] <= count_r;
				end
				default:         readdata_r <= 32'h0000_0000; // Unmapped reads as zero
			endcase
		end
	end

	// Control register; change between accesses only, it is read every cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r <= `DPE_CTRL_RST;
		end else if (bus_wr_now && (avs_address == `DPE_CTRL_OFS) && avs_byteenable[0]) begin
			ctrl_r <= avs_writedata[7:0];
		end
	end

	// Timing register: turnaround after reads and extra strobe margin
	always_ff @(posedge clk) begin
		if (srst) begin
			timing_r <= `DPE_TIMING_RST;
		end else if (bus_wr_now && (avs_address == `DPE_TIMING_OFS) && avs_byteenable[0]) begin
			timing_r <= avs_writedata[7:0];
		end
	end

	// Error flag; a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (srst) begin
			err_r <= 1'b0;
		end else if (err_set) begin
			err_r <= 1'b1;
		end else if (err_clr) begin
			err_r <= 1'b0;
		end
	end

	// Completed access counter, wraps
	always_ff @(posedge clk) begin
		if (srst) begin
			count_r <= CNT_W'(`DPE_COUNT_RST);
		end else if (done_r && !err_pulse_r) begin
			count_r <= count_r + CNT_W'(1);
		end
	end

	// Access sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r      <= DPE_ST_IDLE;
			cnt_r        <= 4'h0;
			beats_left_r <= 3'h0;
			cur_odd_r    <= 1'b0;
			lat_write_r  <= 1'b0;
			lat_il_r     <= 1'b0;
			lat_burst_r  <= 1'b0;
			rows_r       <= 4'h0;
		end else begin
			case (state_r)
				DPE_ST_IDLE: begin
					if (start && !bank_absent) begin
						lat_write_r  <= acc_write;
						lat_il_r     <= il_ok;
						lat_burst_r  <= (acc_beats > 3'h1);
						beats_left_r <= (acc_beats == 3'h0) ? 3'h1 : acc_beats;
						cur_odd_r    <= acc_bank[0];                     // R9
						// Only the addressed bank, or its pair, sees a row strobe
						rows_r       <= il_ok ? (bank_mask(acc_bank) |
							bank_mask(acc_bank ^ 2'h1)) : bank_mask(acc_bank); // R15
						cnt_r        <= margin;                          // R14
						state_r      <= DPE_ST_ROW;
					end
				end
				DPE_ST_ROW: begin
					if (cnt_r == 4'h0) begin
						cnt_r   <= margin;
						state_r <= DPE_ST_COL;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				DPE_ST_COL: begin
					if (cnt_r != 4'h0) begin
						cnt_r <= cnt_r - 4'h1;
					end else begin
						beats_left_r <= beats_left_r - 3'h1;
						cnt_r        <= margin;
						if (lat_il_r) begin
							cur_odd_r <= ~cur_odd_r;   // R10
						end
						if (beats_left_r == 3'h1) begin
							// Plain buffers cannot pipeline: one extra clock on burst reads
							if (!lat_write_r && lat_burst_r && ptype == DPE_PLAIN) begin // R2
								state_r <= DPE_ST_TAIL;
							end else if (!lat_write_r && turn_cycles != 4'h0) begin // R7
								cnt_r   <= turn_cycles - 4'h1;
								state_r <= DPE_ST_TURN;
							end else begin
								state_r <= DPE_ST_IDLE;
							end
						end
					end
				end
				DPE_ST_TAIL: begin
					if (turn_cycles != 4'h0) begin
						cnt_r   <= turn_cycles - 4'h1;   // R13
						state_r <= DPE_ST_TURN;
					end else begin
						state_r <= DPE_ST_IDLE;
					end
				end
				DPE_ST_TURN: begin
					// Bus turnaround after a read; no new access meanwhile
					if (cnt_r == 4'h0) begin
						state_r <= DPE_ST_IDLE;          // R13
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				default: begin
					state_r <= DPE_ST_IDLE;
				end
			endcase
		end
	end

	// Ready: high in idle, dropped for the cycle after each accepted request
	always_ff @(posedge clk) begin
		if (srst) begin
			ready_r <= 1'b0;
		end else if (start) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= (state_r == DPE_ST_IDLE);
		end
	end

	// Beat, done and error pulses toward the requester
	always_ff @(posedge clk) begin
		if (srst) begin
			beat_r      <= 1'b0;
			done_r      <= 1'b0;
			err_pulse_r <= 1'b0;
		end else begin
			beat_r      <= beat_now;
			err_pulse_r <= err_set;
			done_r      <= err_set | (last_beat && (lat_write_r || !lat_burst_r ||
				ptype != DPE_PLAIN)) | (state_r == DPE_ST_TAIL);
		end
	end

	// Row and column strobes, active low
	always_ff @(posedge clk) begin
		if (srst) begin
			row_n_r <= 4'hf;
			col_n_r <= 1'b1;
		end else begin
			if ((state_r == DPE_ST_ROW) || (state_r == DPE_ST_COL) ||
				(state_r == DPE_ST_TAIL)) begin
				row_n_r <= ~rows_r;                              // R9
			end else begin
				row_n_r <= 4'hf;
			end
			// Column strobe is shared; banks without row strobe ignore it
			col_n_r <= ~(state_r == DPE_ST_COL);             // R11
		end
	end

	// Path enables, active low; idle path stays off
	always_ff @(posedge clk) begin
		if (srst) begin
			erd_n_r <= 1'b1;
			ord_n_r <= 1'b1;
			ewr_n_r <= 1'b1;
			owr_n_r <= 1'b1;
		end else begin
			erd_n_r <= ~dif.even_rd;                         // R15
			ord_n_r <= ~dif.odd_rd;                          // R15
			ewr_n_r <= ~dif.even_wr;
			owr_n_r <= ~dif.odd_wr;
		end
	end

	// Port images, all straight from flip-flops
	assign avs_readdata             = readdata_r;
	assign avs_waitrequest          = waitreq_r;
	assign acc_ready                = ready_r;
	assign acc_beat                 = beat_r;
	assign acc_done                 = done_r;
	assign acc_error                = err_pulse_r;
	assign row_strobe_n             = row_n_r;
	assign col_strobe_n             = col_n_r;
	assign even_read_path_enable_n  = erd_n_r;
	assign odd_read_path_enable_n   = ord_n_r;
	assign even_write_path_enable_n = ewr_n_r;
	assign odd_write_path_enable_n  = owr_n_r;

endmodule : dpe_top

//--- dpe_top_assertions.sv
// Port-level checker of the data-path enable block
`timescale 1ns/10ps
module dpe_top_assertions #(
	parameter int CNT_W = 16
)
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic        acc_valid,
	input wire logic        acc_ready,
	input wire logic        acc_done,
	input wire logic        acc_error,
	input wire logic [3:0]  row_strobe_n,
	input wire logic        col_strobe_n,
	input wire logic        even_read_path_enable_n,
	input wire logic        odd_read_path_enable_n,
	input wire logic        even_write_path_enable_n,
	input wire logic        odd_write_path_enable_n
);
	logic [1:0] type_r;
	logic       lat;
	logic       plain;

	// Shadow of the buffer kind, so enable rules can be judged per kind
	always_ff @(posedge clk) begin
		if (srst)
			type_r <= 2'h0;
		else if (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0])
			type_r <= avs_writedata[1:0];
	end

	// Spare code 3 behaves as the plain kind
	assign lat   = type_r == 2'h1;
	assign plain = type_r[0] == type_r[1];

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered in one cycle");
	ready_drop_a: assert property (acc_valid && acc_ready |=> !acc_ready)
		else $error("ready stayed high after take");
	done_bound_a: assert property (acc_valid && acc_ready |-> ##[1:100] acc_done)
		else $error("access never completed");
	absent_quiet_a: assert property (acc_error |-> acc_done && row_strobe_n == 4'hf)
		else $error("rejected access drove strobes");
	one_wpath_a: assert property (!(!even_write_path_enable_n && !odd_write_path_enable_n))
		else $error("both write paths enabled");
	col_row_a: assert property (!col_strobe_n |-> row_strobe_n != 4'hf)
		else $error("column strobe without row strobe");
	plain_oe_a: assert property (plain |-> (even_write_path_enable_n || !even_read_path_enable_n)
		&& (odd_write_path_enable_n || !odd_read_path_enable_n))
		else $error("plain write without buffer enable");
	lat_read_a: assert property (lat && !odd_read_path_enable_n && odd_write_path_enable_n
		&& even_write_path_enable_n |-> !even_read_path_enable_n)
		else $error("odd latch without common read enable");
endmodule : dpe_top_assertions

bind dpe_top dpe_top_assertions #(.CNT_W(CNT_W)) u_dpe_chk (.clk(clk), .srst(srst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid), .acc_ready(acc_ready),
	.acc_done(acc_done), .acc_error(acc_error), .row_strobe_n(row_strobe_n),
	.col_strobe_n(col_strobe_n), .even_read_path_enable_n(even_read_path_enable_n),
	.odd_read_path_enable_n(odd_read_path_enable_n),
	.even_write_path_enable_n(even_write_path_enable_n),
	.odd_write_path_enable_n(odd_write_path_enable_n));

//--- dpe_bank_model.sv
// Bank model: records which banks accept a column strobe
`timescale 1ns/10ps
module dpe_bank_model (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       acc_take,
	input wire logic [3:0] row_strobe_n,
	input wire logic       col_strobe_n,
	output logic     [3:0] bank_hit
);
	// A bank ignores a column strobe unless its own row strobe is low
	always_ff @(posedge clk) begin
		if (srst || acc_take)
			bank_hit <= 4'h0;
		else if (!col_strobe_n)
			bank_hit <= bank_hit | ~row_strobe_n;
	end
endmodule : dpe_bank_model

//--- test_dpe_top.sv
// Self-checking bench of the data-path enable block
`timescale 1ns/10ps
module test_dpe_top;
	logic        clk, srst, avs_read, avs_write, acc_valid, acc_write, acc_interleave;
	logic [3:0]  avs_address, avs_byteenable, row_strobe_n, bank_hit, en_seen, rows_seen;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic        avs_waitrequest, acc_ready, acc_beat, acc_done, acc_error, col_strobe_n;
	logic        erd_n, ord_n, ewr_n, owr_n, err_seen;
	logic [1:0]  acc_bank;
	logic [2:0]  acc_beats;
	logic [11:0] rows [8];
	int          miscompares, samples_checked, cycles, lat, nb, lat0, lat1, gap;

	dpe_top dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_bank(acc_bank), .acc_beats(acc_beats),
		.acc_interleave(acc_interleave), .acc_ready(acc_ready), .acc_beat(acc_beat),
		.acc_done(acc_done), .acc_error(acc_error), .row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n), .even_read_path_enable_n(erd_n),
		.odd_read_path_enable_n(ord_n), .even_write_path_enable_n(ewr_n),
		.odd_write_path_enable_n(owr_n));

	dpe_bank_model u_banks (.clk(clk), .srst(srst), .acc_take(acc_valid && acc_ready),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .bank_hit(bank_hit));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task conclude;
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// One Avalon transfer; the leading edge keeps strobes from being set twice in a step
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// One edge of access monitoring
	task tick;
		@(posedge clk);
		en_seen |= ~{erd_n, ord_n, ewr_n, owr_n};
		rows_seen |= ~row_strobe_n;
		if (acc_beat === 1'b1)
			nb++;
		if (acc_error === 1'b1)
			err_seen = 1'b1;
	endtask : tick

	task acc(input logic wr, input logic [1:0] b, input logic [2:0] n, input logic il);
		@(posedge clk);
		acc_write <= wr;
		acc_bank <= b;
		acc_beats <= n;
		acc_interleave <= il;
		acc_valid <= 1'b1;
		do @(posedge clk); while (acc_ready !== 1'b1);
		acc_valid <= 1'b0;
		lat = 0;
		nb = 0;
		en_seen = 4'h0;
		rows_seen = 4'h0;
		err_seen = 1'b0;
		do begin
			tick();
			lat++;
		end while (acc_done !== 1'b1);
		// Edges from done until ready returns; turnaround stretches this
		gap = 0;
		do begin
			tick();
			gap++;
		end while (acc_ready !== 1'b1);
	endtask : acc

	initial begin
		{srst, avs_read, avs_write, acc_valid, acc_write, acc_interleave} = 6'h20;
		{avs_address, avs_writedata, acc_bank, acc_beats} = '0;
		avs_byteenable = 4'hf;
		{miscompares, samples_checked} = '0;
		// Kind, write, bank, beats, expected enables {even_rd, odd_rd, even_wr, odd_wr}
		rows = '{12'h048, 12'h448, 12'h295, 12'h4ac, 12'h712, 12'h9b4, 12'haa1, 12'hd18};
		repeat (10) @(posedge clk);
		check(row_strobe_n, 4'hf);
		check(avs_waitrequest, 1'b1);
		check(acc_ready, 1'b0);
		srst <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		check(q, 32'hf4);
		bus(1'b0, 4'h4, 32'h0);
		check(q, 32'h0);
		bus(1'b0, 4'hc, 32'h0);
		check(q, 32'h0);
		// Table of single accesses over every buffer kind
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 4'h0, {24'h0, 6'h3d, rows[i][11:10]});
			// Write flag plays the system strobe that turns the board's buffers
			acc(rows[i][9], rows[i][8:7], rows[i][6:4], 1'b0);
			if (i == 0)
				lat0 = lat;
			if (i == 1)
				lat1 = lat;
			check(en_seen, rows[i][3:0]);
			check(rows_seen, 4'h1 << rows[i][8:7]);
			check(bank_hit, 4'h1 << rows[i][8:7]);
			check(nb, rows[i][6:4]);
		end
		check(lat0 - lat1, 1);
		// Margin adds one to row phase and to each beat
		bus(1'b1, 4'h4, 32'h10);
		bus(1'b1, 4'h0, 32'hf5);
		acc(1'b0, 2'h0, 3'h4, 1'b0);
		check(lat - lat1, 5);
		// Turnaround of two cycles holds ready off two edges longer
		bus(1'b1, 4'h4, 32'h2);
		acc(1'b0, 2'h0, 3'h1, 1'b0);
		check(gap, 3);
		bus(1'b1, 4'h4, 32'h0);
		// Interleave on split paths, then on a shared path
		bus(1'b1, 4'h0, 32'hf6);
		acc(1'b0, 2'h0, 3'h2, 1'b1);
		check(rows_seen, 4'h3);
		check(bank_hit, 4'h3);
		check(en_seen, 4'hc);
		bus(1'b1, 4'h0, 32'hf0);
		acc(1'b0, 2'h0, 3'h2, 1'b1);
		check(rows_seen, 4'h1);
		// Absent bank is refused and flagged
		bus(1'b1, 4'h0, 32'h54);
		acc(1'b0, 2'h1, 3'h1, 1'b0);
		check(err_seen, 1'b1);
		check(rows_seen, 4'h0);
		bus(1'b0, 4'h8, 32'h0);
		check(q[1], 1'b1);
		// Twelve completed accesses, idle state, error set, not busy
		check(q, 32'h000c_0012);
		bus(1'b1, 4'h8, 32'h2);
		bus(1'b0, 4'h8, 32'h0);
		check(q[1], 1'b0);
		conclude();
	end
endmodule : test_dpe_top
